//--- include/capture_compare_pwm_pkg.sv
// constants, register map and mode codes of the capture/compare/pwm unit
// How it works
// - a capture event copies the whole 16-bit timer one count into both bytes
// - capture event: falling edge, rising edge, every 4th or 16th rising edge
// - each capture sets the unit event flag, bit 2; only software clears it
// - a newer capture silently overwrites an unread older one
// - capture edges come from the pin level even when the pin drives out
// - a capture mode change may raise a false flag; software masks and clears it
// - the capture prescaler counter is held clear unless in capture mode
// - direct prescale switches keep the count; software writes zero first
// - compare mode matches 16-bit value to timer one, sets flag; set and clear modes act on pin
// - writing zero to the control register forces the compare latch low
// - software interrupt compare mode leaves the pin alone, only sets the flag
// - special event match resets timer one and starts a conversion if enabled
// - the special event reset never sets the timer one overflow flag, bit 0
// - pwm period is (period plus one) times four clocks times timer two prescale
// - at period end: clear timer two, set pin unless duty zero, buffer duty
// - duty is 10 bits: low byte on top, control bits 5:4 below
// - duty writes apply only at period end; buffer byte is read-only in pwm
// - pin clears when buffered duty equals timer two plus two phase bits
// - a duty longer than the period never clears the pin
// - writing zero to the control register forces the pwm latch low
// - mode field decodes off, four captures, four compares and pwm
// - timer two counts up to its period value, then returns to zero
package capture_compare_pwm_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_FLAG = 8'h0c;
    localparam logic [7:0] IDX_T2_COUNT = 8'h11;
    localparam logic [7:0] IDX_T2_CONTROL = 8'h12;
    localparam logic [7:0] IDX_LOW = 8'h15;
    localparam logic [7:0] IDX_HIGH = 8'h16;
    localparam logic [7:0] IDX_CONTROL = 8'h17;
    localparam logic [7:0] IDX_T2_PERIOD = 8'h92;

    localparam logic [9:0] ADDR_FLAG = {IDX_FLAG, 2'b00};
    localparam logic [9:0] ADDR_T2_COUNT = {IDX_T2_COUNT, 2'b00};
    localparam logic [9:0] ADDR_T2_CONTROL = {IDX_T2_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_LOW = {IDX_LOW, 2'b00};
    localparam logic [9:0] ADDR_HIGH = {IDX_HIGH, 2'b00};
    localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_T2_PERIOD = {IDX_T2_PERIOD, 2'b00};

    // field positions
    localparam int FLAG_T1_OVF_BIT = 0;
    localparam int FLAG_T2_MATCH_BIT = 1;
    localparam int FLAG_UNIT_BIT = 2;
    localparam int CTL_DUTY_LSB = 4;
    localparam int T2_ON_BIT = 2;

    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] T2_PERIOD_RST = 8'hff;
    localparam logic [6:0] T2_CONTROL_RST = 7'h00;

    // mode field codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
    localparam logic [1:0] GROUP_CAPTURE = 2'h1;
    localparam logic [1:0] GROUP_COMPARE = 2'h2;
    localparam logic [1:0] GROUP_PWM = 2'h3;

    // timing: one instruction cycle is four clocks, prescale 1, 4 or 16
    localparam logic [1:0] Q_PHASE_LAST = 2'h3;
    localparam logic [3:0] PSC_LAST_1 = 4'h0;
    localparam logic [3:0] PSC_LAST_4 = 4'h3;
    localparam logic [3:0] PSC_LAST_16 = 4'hf;
    localparam logic [1:0] CAP_LAST_4 = 2'h3;
    localparam logic [3:0] CAP_LAST_16 = 4'hf;

endpackage

//--- hdl/capture_compare_pwm_unit.sv
// capture/compare/pwm unit with its timer two time base and avalon-mm slave
`timescale 1ns/1ps
module capture_compare_pwm_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [9:0] avm_address,
    input wire logic avm_read,
    input wire logic avm_write,
    input wire logic [31:0] avm_writedata,
    input wire logic [3:0] avm_byteenable,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    input wire logic [15:0] timer_one_count,
    input wire logic timer_one_wrap,
    input wire logic converter_enable,
    input wire logic unit_pin_in,
    output logic unit_pin_out,
    output logic unit_pin_oe_n,
    output logic timer_one_reset,
    output logic adc_start,
    output logic unit_event_flag
);

    // bus state
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;

    // unit state
    logic [7:0] control_q, control_d;
    logic [7:0] low_q, low_d;
    logic [7:0] high_q, high_d;
    logic [2:0] flag_q, flag_d;
    logic [3:0] cap_cnt_q, cap_cnt_d;
    logic pin_prev_q, pin_prev_d;
    logic match_prev_q, match_prev_d;
    logic cmp_q, cmp_d;
    logic t1_reset_q, t1_reset_d;
    logic adc_q, adc_d;

    // timer two and pwm state
    logic [7:0] t2_count_q, t2_count_d;
    logic [7:0] t2_period_q, t2_period_d;
    logic [6:0] t2_control_q, t2_control_d;
    logic [1:0] q_phase_q, q_phase_d;
    logic [3:0] psc_q, psc_d;
    logic [1:0] duty_lat_q, duty_lat_d;
    logic pwm_q, pwm_d;

    // pin state
    logic pin_q, pin_d;
    logic oe_n_q, oe_n_d;

    // decode
    logic [3:0] mode;
    logic is_cap, is_cmp, is_pwm;
    logic wr_acc;
    logic [7:0] wdat;
    logic wr_flag, wr_t2_count, wr_t2_control, wr_low, wr_high, wr_control, wr_t2_period;
    logic ctl_zero_wr;
    logic rise, fall, cap_evt;
    logic match, match_new;
    logic t2_on, q_end, t2_tick, period_end;
    logic [3:0] psc_last;
    logic [1:0] ext_bits;
    logic [9:0] duty_new;
    logic duty_match;
    logic [7:0] rd_mux;

    assign mode = control_q[3:0];
    assign is_cap = mode[3:2] == capture_compare_pwm_pkg::GROUP_CAPTURE;
    assign is_cmp = mode[3:2] == capture_compare_pwm_pkg::GROUP_COMPARE;
    assign is_pwm = mode[3:2] == capture_compare_pwm_pkg::GROUP_PWM;

    // a write lands at the edge where waitrequest is seen low; only lane 0 carries data
    assign wr_acc = avm_write && !wait_q && avm_byteenable[0];
    assign wdat = avm_writedata[7:0];
    assign wr_flag = wr_acc && avm_address == capture_compare_pwm_pkg::ADDR_FLAG;
    assign wr_t2_count = wr_acc && avm_address == capture_compare_pwm_pkg::ADDR_T2_COUNT;
    assign wr_t2_control = wr_acc && avm_address == capture_compare_pwm_pkg::ADDR_T2_CONTROL;
    assign wr_low = wr_acc && avm_address == capture_compare_pwm_pkg::ADDR_LOW;
    assign wr_high = wr_acc && avm_address == capture_compare_pwm_pkg::ADDR_HIGH;
    assign wr_control = wr_acc && avm_address == capture_compare_pwm_pkg::ADDR_CONTROL;
    assign wr_t2_period = wr_acc && avm_address == capture_compare_pwm_pkg::ADDR_T2_PERIOD;
    assign ctl_zero_wr = wr_control && wdat == 8'h00;

    // the pad level is watched whatever the direction, so port writes can capture
    assign rise = unit_pin_in && !pin_prev_q;
    assign fall = !unit_pin_in && pin_prev_q;

    // edge history runs across mode changes, which is why a switch may fire once
    always_comb begin
        case (mode)
            capture_compare_pwm_pkg::MODE_CAP_FALL: cap_evt = fall;
            capture_compare_pwm_pkg::MODE_CAP_RISE: cap_evt = rise;
            capture_compare_pwm_pkg::MODE_CAP_RISE4: begin
                cap_evt = rise && cap_cnt_q[1:0] == capture_compare_pwm_pkg::CAP_LAST_4;
            end
            capture_compare_pwm_pkg::MODE_CAP_RISE16: begin
                cap_evt = rise && cap_cnt_q == capture_compare_pwm_pkg::CAP_LAST_16;
            end
            default: cap_evt = 1'b0;
        endcase
    end

    assign match = is_cmp && {high_q, low_q} == timer_one_count;
    // timer one may rest on the value for many clocks; act once per arrival
    assign match_new = match && !match_prev_q;

    // timer two time base
    assign t2_on = t2_control_q[capture_compare_pwm_pkg::T2_ON_BIT];
    assign q_end = q_phase_q == capture_compare_pwm_pkg::Q_PHASE_LAST;
    always_comb begin
        case (t2_control_q[1:0])
            2'h0: begin
                psc_last = capture_compare_pwm_pkg::PSC_LAST_1;
                ext_bits = q_phase_q;
            end
            2'h1: begin
                psc_last = capture_compare_pwm_pkg::PSC_LAST_4;
                ext_bits = psc_q[1:0];
            end
            default: begin
                psc_last = capture_compare_pwm_pkg::PSC_LAST_16;
                ext_bits = psc_q[3:2];
            end
        endcase
    end
    assign t2_tick = t2_on && q_end && psc_q == psc_last;
    assign period_end = t2_tick && t2_count_q == t2_period_q;
    assign duty_new = {low_q, control_q[5:capture_compare_pwm_pkg::CTL_DUTY_LSB]};
    // a buffered duty above the period never equals the count, so no clear
    assign duty_match = {high_q, duty_lat_q} == {t2_count_q, ext_bits};

    // capture, compare and flags
    always_comb begin
        control_d = control_q;
        low_d = low_q;
        high_d = high_q;
        flag_d = flag_q;
        cap_cnt_d = cap_cnt_q;
        cmp_d = cmp_q;
        pin_prev_d = unit_pin_in;
        match_prev_d = match;
        t1_reset_d = 1'b0;
        adc_d = 1'b0;
        if (wr_control) begin
            control_d = {2'b00, wdat[5:0]};
        end
        if (!is_cap) begin
            cap_cnt_d = 4'h0;
        end else if (rise) begin
            cap_cnt_d = cap_cnt_q + 4'h1;
        end
        if (wr_low) begin
            low_d = wdat;
        end
        if (wr_high && !is_pwm) begin
            high_d = wdat;
        end
        if (is_pwm && period_end) begin
            high_d = low_q;
        end
        // a capture wins over a software write in the same cycle
        if (cap_evt) begin
            low_d = timer_one_count[7:0];
            high_d = timer_one_count[15:8];
        end
        if (ctl_zero_wr) begin
            cmp_d = 1'b0;
        end else if (match_new && mode == capture_compare_pwm_pkg::MODE_CMP_SET) begin
            cmp_d = 1'b1;
        end else if (match_new && mode == capture_compare_pwm_pkg::MODE_CMP_CLEAR) begin
            cmp_d = 1'b0;
        end
        if (match_new && mode == capture_compare_pwm_pkg::MODE_CMP_SPECIAL) begin
            t1_reset_d = 1'b1;
            adc_d = converter_enable;
        end
        if (wr_flag) begin
            flag_d = wdat[2:0];
        end
        // hardware sets win over a clearing write in the same cycle
        if (cap_evt || match_new) begin
            flag_d[capture_compare_pwm_pkg::FLAG_UNIT_BIT] = 1'b1;
        end
        if (period_end) begin
            flag_d[capture_compare_pwm_pkg::FLAG_T2_MATCH_BIT] = 1'b1;
        end
        // only the timer's own wrap sets the overflow flag, never the special event
        if (timer_one_wrap) begin
            flag_d[capture_compare_pwm_pkg::FLAG_T1_OVF_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            control_q <= capture_compare_pwm_pkg::CONTROL_RST;
            low_q <= 8'h00;
            high_q <= 8'h00;
            flag_q <= 3'h0;
            cap_cnt_q <= 4'h0;
            pin_prev_q <= 1'b0;
            match_prev_q <= 1'b0;
            cmp_q <= 1'b0;
            t1_reset_q <= 1'b0;
            adc_q <= 1'b0;
        end else begin
            control_q <= control_d;
            low_q <= low_d;
            high_q <= high_d;
            flag_q <= flag_d;
            cap_cnt_q <= cap_cnt_d;
            pin_prev_q <= pin_prev_d;
            match_prev_q <= match_prev_d;
            cmp_q <= cmp_d;
            t1_reset_q <= t1_reset_d;
            adc_q <= adc_d;
        end
    end

    // timer two and pwm
    always_comb begin
        t2_count_d = t2_count_q;
        t2_period_d = t2_period_q;
        t2_control_d = t2_control_q;
        q_phase_d = q_phase_q + 2'h1;
        psc_d = psc_q;
        duty_lat_d = duty_lat_q;
        pwm_d = pwm_q;
        if (t2_on && q_end) begin
            psc_d = (psc_q == psc_last) ? 4'h0 : psc_q + 4'h1;
        end
        // writes to the count or control restart the prescaler
        if (wr_t2_count || wr_t2_control) begin
            psc_d = 4'h0;
        end
        if (period_end) begin
            t2_count_d = 8'h00;
        end else if (t2_tick) begin
            t2_count_d = t2_count_q + 8'h01;
        end
        if (wr_t2_count) begin
            t2_count_d = wdat;
        end
        if (wr_t2_period) begin
            t2_period_d = wdat;
        end
        if (wr_t2_control) begin
            t2_control_d = wdat[6:0];
        end
        if (is_pwm && period_end) begin
            duty_lat_d = control_q[5:capture_compare_pwm_pkg::CTL_DUTY_LSB];
        end
        if (ctl_zero_wr) begin
            pwm_d = 1'b0;
        end else if (is_pwm && period_end) begin
            pwm_d = duty_new != 10'h000;
        end else if (is_pwm && duty_match) begin
            pwm_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            t2_count_q <= 8'h00;
            t2_period_q <= capture_compare_pwm_pkg::T2_PERIOD_RST;
            t2_control_q <= capture_compare_pwm_pkg::T2_CONTROL_RST;
            q_phase_q <= 2'h0;
            psc_q <= 4'h0;
            duty_lat_q <= 2'h0;
            pwm_q <= 1'b0;
        end else begin
            t2_count_q <= t2_count_d;
            t2_period_q <= t2_period_d;
            t2_control_q <= t2_control_d;
            q_phase_q <= q_phase_d;
            psc_q <= psc_d;
            duty_lat_q <= duty_lat_d;
            pwm_q <= pwm_d;
        end
    end

    // pin driver: one clock behind the latches so the pad comes from a flop
    always_comb begin
        pin_d = 1'b0;
        oe_n_d = 1'b1;
        if (is_pwm) begin
            // cut the pad at the match itself, else the pulse runs one clock long
            pin_d = pwm_q && !duty_match;
            oe_n_d = 1'b0;
        end else if (is_cmp) begin
            pin_d = cmp_q;
            oe_n_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            pin_q <= pin_d;
            oe_n_q <= oe_n_d;
        end
    end

    // bus slave: two clocks per access, read data staged while waitrequest is high
    always_comb begin
        case (avm_address)
            capture_compare_pwm_pkg::ADDR_FLAG: rd_mux = {5'h00, flag_q};
            capture_compare_pwm_pkg::ADDR_T2_COUNT: rd_mux = t2_count_q;
            capture_compare_pwm_pkg::ADDR_T2_CONTROL: rd_mux = {1'b0, t2_control_q};
            capture_compare_pwm_pkg::ADDR_LOW: rd_mux = low_q;
            capture_compare_pwm_pkg::ADDR_HIGH: rd_mux = high_q;
            capture_compare_pwm_pkg::ADDR_CONTROL: rd_mux = control_q;
            capture_compare_pwm_pkg::ADDR_T2_PERIOD: rd_mux = t2_period_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        wait_d = !(wait_q && (avm_read || avm_write));
        rdata_d = rdata_q;
        if (wait_q && avm_read) begin
            rdata_d = {24'h000000, rd_mux};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avm_readdata = rdata_q;
    assign avm_waitrequest = wait_q;
    assign unit_pin_out = pin_q;
    assign unit_pin_oe_n = oe_n_q;
    assign timer_one_reset = t1_reset_q;
    assign adc_start = adc_q;
    assign unit_event_flag = flag_q[capture_compare_pwm_pkg::FLAG_UNIT_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    capture_load_a: assert property (cap_evt |=> {high_q, low_q} == $past(timer_one_count))
        else $error("capture did not load the timer one count");
    capture_flag_a: assert property (cap_evt |=> unit_event_flag)
        else $error("capture did not set the unit flag");
    rise_four_a: assert property (mode == capture_compare_pwm_pkg::MODE_CAP_RISE4 && cap_evt
        |-> rise && cap_cnt_q[1:0] == 2'h3)
        else $error("fourth rising edge capture at wrong count");
    presc_clear_a: assert property (!is_cap |=> cap_cnt_q == 4'h0)
        else $error("capture prescaler not held clear");
    cmp_set_a: assert property (match_new && mode == capture_compare_pwm_pkg::MODE_CMP_SET
        && !ctl_zero_wr |=> cmp_q ##1 unit_pin_out)
        else $error("set on match did not drive the pin high");
    soft_pin_a: assert property (match_new && mode == capture_compare_pwm_pkg::MODE_CMP_SOFT
        && !wr_control |=> $stable(cmp_q) && unit_event_flag)
        else $error("software interrupt compare touched the pin");
    special_evt_a: assert property (match_new && mode == capture_compare_pwm_pkg::MODE_CMP_SPECIAL
        |=> timer_one_reset && adc_start == $past(converter_enable))
        else $error("special event did not reset timer one");
    ovf_source_a: assert property ($rose(flag_q[0]) |-> $past(timer_one_wrap))
        else $error("overflow flag set without a timer one wrap");
    zero_ctl_a: assert property (ctl_zero_wr |=> !cmp_q && !pwm_q ##1 !unit_pin_out)
        else $error("control clear did not force the latches low");
    period_end_a: assert property (is_pwm && period_end && !wr_t2_count
        |=> t2_count_q == 8'h00 && high_q == $past(low_q))
        else $error("period end did not restart timer two and buffer duty");
    duty_hold_a: assert property (is_pwm && !period_end && !cap_evt |=> $stable(high_q))
        else $error("duty buffer changed inside a pwm period");
    duty_clear_a: assert property (is_pwm && duty_match && !period_end && !wr_control
        |=> !pwm_q)
        else $error("pwm pin not cleared at duty match");
    pin_clear_a: assert property (is_pwm && duty_match && !wr_control |=> !unit_pin_out)
        else $error("pwm pad still high after duty match");
    bus_answer_a: assert property (wait_q && (avm_read || avm_write) |=> !avm_waitrequest
        ##1 avm_waitrequest)
        else $error("bus access not answered in one cycle");

endmodule

//--- tb/pin_load_model.sv
// external load on the unit pin: the pad level seen by the block
`timescale 1ns/1ps
module pin_load_model (
    input wire logic unit_pin_out,
    input wire logic unit_pin_oe_n,
    input wire logic ext_level,
    output logic unit_pin_in
);
    // the pad reads back the block's own drive, so writes can trigger captures
    assign unit_pin_in = unit_pin_oe_n ? ext_level : unit_pin_out;
endmodule

//--- tb/capture_compare_pwm_unit_bench.sv
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/1ps
module capture_compare_pwm_unit_bench;
    localparam logic [9:0] ctl = capture_compare_pwm_pkg::ADDR_CONTROL;
    localparam logic [9:0] flg = capture_compare_pwm_pkg::ADDR_FLAG;
    localparam logic [9:0] lo = capture_compare_pwm_pkg::ADDR_LOW;
    localparam logic [9:0] hi = capture_compare_pwm_pkg::ADDR_HIGH;
    localparam logic [9:0] per = capture_compare_pwm_pkg::ADDR_T2_PERIOD;
    localparam logic [9:0] t2c = capture_compare_pwm_pkg::ADDR_T2_CONTROL;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avm_address = 10'h000;
    logic avm_read = 1'b0;
    logic avm_write = 1'b0;
    logic [31:0] avm_writedata = 32'h0;
    logic [3:0] avm_byteenable = 4'hf;
    logic [31:0] avm_readdata;
    logic avm_waitrequest;
    logic [15:0] timer_one_count = 16'h0;
    logic timer_one_wrap = 1'b0;
    logic converter_enable = 1'b1;
    logic ext_level = 1'b0;
    logic unit_pin_in, unit_pin_out, unit_pin_oe_n, timer_one_reset, adc_start, unit_event_flag;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] resets_seen = 32'h0;
    logic [31:0] starts_seen = 32'h0;
    logic [15:0] seed = 16'h0047;
    logic [31:0] expq[$];
    int nedge[4] = '{1, 2, 4, 16};
    logic [3:0] cmode[7] = '{4'h8, 4'ha, 4'h0, 4'h8, 4'h9, 4'hb, 4'hb};
    logic [6:0] cpin = 7'h0b;
    logic [1:0] pcode[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
    logic [9:0] pduty[5] = '{10'h0, 10'h5, 10'h5, 10'h0, 10'h14};

    always #2.5 clk_sys = ~clk_sys;

    capture_compare_pwm_unit capture_compare_pwm_unit_inst (
        .clk_sys(clk_sys), .rst(rst), .avm_address(avm_address), .avm_read(avm_read),
        .avm_write(avm_write), .avm_writedata(avm_writedata),
        .avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata),
        .avm_waitrequest(avm_waitrequest), .timer_one_count(timer_one_count),
        .timer_one_wrap(timer_one_wrap), .converter_enable(converter_enable),
        .unit_pin_in(unit_pin_in), .unit_pin_out(unit_pin_out),
        .unit_pin_oe_n(unit_pin_oe_n), .timer_one_reset(timer_one_reset),
        .adc_start(adc_start), .unit_event_flag(unit_event_flag));
    pin_load_model pin_load_model_inst (.unit_pin_out(unit_pin_out),
        .unit_pin_oe_n(unit_pin_oe_n), .ext_level(ext_level), .unit_pin_in(unit_pin_in));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // read data is taken off the queue at the edge that accepts the read
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (timer_one_reset === 1'b1) resets_seen <= resets_seen + 1;
        if (adc_start === 1'b1) starts_seen <= starts_seen + 1;
        if (avm_read === 1'b1 && avm_waitrequest === 1'b0) begin
            chk("read data", expq.pop_front(), avm_readdata);
        end
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge clk_sys);
        avm_address <= a;
        avm_writedata <= {24'h0, d};
        avm_byteenable <= be;
        avm_read <= !wr;
        avm_write <= wr;
        do @(posedge clk_sys); while (avm_waitrequest !== 1'b0);
        avm_read <= 1'b0;
        avm_write <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        expq.push_back({24'h0, exp});
        bus(1'b0, a, 8'h00, 4'hf);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    initial begin
        int w;
        int psc;
        logic [9:0] d;
        logic [31:0] cnt;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ctl, 8'h00);
        rd(per, 8'hff);
        bus(1'b1, ctl, 8'h0c, 4'he);
        rd(ctl, 8'h00);
        rd(10'h055, 8'h00);
        @(posedge clk_sys);
        timer_one_wrap <= 1'b1;
        @(posedge clk_sys);
        timer_one_wrap <= 1'b0;
        rd(flg, 8'h01);
        wr(flg, 8'h00);
        $display("reset and map test done");
        for (int m = 0; m < 4; m++) begin
            wr(ctl, 8'h00);
            wr(ctl, 8'h04 + m[7:0]);
            wr(flg, 8'h00);
            for (int e = 1; e <= nedge[m]; e++) begin
                seed = lfsr(seed);
                timer_one_count <= seed;
                ext_level <= 1'b1;
                tick(3);
                ext_level <= 1'b0;
                tick(3);
                if (m >= 2 && e == nedge[m] - 1) rd(flg, 8'h00);
            end
            rd(flg, 8'h04);
            chk("unit flag pin", 32'h1, {31'h0, unit_event_flag});
            rd(lo, seed[7:0]);
            rd(hi, seed[15:8]);
        end
        $display("capture test done");
        seed = lfsr(seed);
        wr(lo, seed[7:0]);
        wr(hi, seed[15:8]);
        for (int i = 0; i < 7; i++) begin
            converter_enable <= (i != 6);
            timer_one_count <= ~seed;
            wr(ctl, {4'h0, cmode[i]});
            timer_one_count <= seed;
            tick(4);
            chk("compare pin", {31'h0, cpin[i]}, {31'h0, unit_pin_out});
            chk("pin drive", {31'h0, cmode[i] == 4'h0}, {31'h0, unit_pin_oe_n});
            rd(flg, (cmode[i] == 4'h0) ? 8'h00 : 8'h04);
            wr(flg, 8'h00);
        end
        chk("trigger pulses", 32'h2, resets_seen);
        chk("conversion starts", 32'h1, starts_seen);
        $display("compare test done");
        wr(per, 8'h03);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            d = (i == 0) ? {6'h0, seed[3:0]} : pduty[i];
            psc = 1 << (2 * pcode[i]);
            w = 16 * psc;
            wr(lo, d[9:2]);
            wr(t2c, {5'h1, pcode[i]});
            wr(ctl, {2'h0, d[1:0], 4'hc});
            tick(3 * w);
            cnt = 32'h0;
            repeat (w) begin
                @(posedge clk_sys);
                cnt = cnt + {31'h0, unit_pin_out};
            end
            chk("pwm high time", ((d > 16) ? 16 : d) * psc, cnt);
        end
        rd(hi, 8'h05);
        wr(hi, 8'h55);
        rd(hi, 8'h05);
        wr(ctl, 8'h00);
        tick(3);
        chk("pwm idle pin", 32'h0, {31'h0, unit_pin_out});
        $display("pwm test done");
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        rd(ctl, 8'h00);
        rd(per, 8'hff);
        $display("second reset test done");
        wrap_up();
    end
endmodule
